// ---- rtl/fcrv_defs.svh ----
// Offsets, field positions, codes and counts of the floppy command sequencer
`ifndef FCRV_DEFS_SVH
`define FCRV_DEFS_SVH

// Register byte offsets
`define FCRV_OFF_DATA      8'h00
`define FCRV_OFF_STATUS    8'h04
`define FCRV_OFF_IRQ_STAT  8'h08
`define FCRV_OFF_IRQ_MASK  8'h0c
`define FCRV_OFF_CTRL      8'h10

// Status register bit positions
`define FCRV_ST_BUSY       0
`define FCRV_ST_EXEC       1
`define FCRV_ST_RESULT     2
`define FCRV_ST_WR_FULL    3

// Interrupt bits, same layout in status and mask
`define FCRV_IRQ_W         3
`define FCRV_IRQ_RESULT    0
`define FCRV_IRQ_INVALID   1
`define FCRV_IRQ_EXEC      2
`define FCRV_IRQ_RESET     3'h0

// Control register bit positions
`define FCRV_CTRL_ABORT    0

// Command byte decode: masked value compared against code; version code compared unmasked
`define FCRV_RDID_MASK     8'hbf
`define FCRV_RDID_CODE     8'h0a
`define FCRV_VERIFY_MASK   8'h1f
`define FCRV_VERIFY_CODE   8'h16
`define FCRV_WRITE_MASK    8'h3f
`define FCRV_WRITE_CODE    8'h05
`define FCRV_VERSION_CODE  8'h10

// Command byte flag positions
`define FCRV_B_MULTI_TRACK 7
`define FCRV_B_DOUBLE_DENS 6
`define FCRV_B_SKIP_DEL    5
// Select byte flag positions
`define FCRV_B_ENABLE_CNT  7
`define FCRV_B_HEAD        2

// Parameter byte counts and last result byte indices
`define FCRV_NPAR_RDID     4'h1
`define FCRV_NPAR_LONG     4'h8
`define FCRV_NRES_FULL     3'h6
`define FCRV_NRES_ONE      3'h0

// Fixed answers
`define FCRV_VERSION_ANS   8'h90
`define FCRV_INVALID_ANS   8'h80

`endif

// ---- rtl/fcrv_pkg.sv ----
// Types shared by the floppy command sequencer and its surroundings
`default_nettype none
package fcrv_pkg;

   typedef enum logic [1:0] {
      FCRV_IDLE   = 2'b00,
      FCRV_PARAM  = 2'b01,
      FCRV_EXEC   = 2'b10,
      FCRV_RESULT = 2'b11
   } fcrv_state_t;

   typedef enum logic [1:0] {
      FCRV_OP_READID  = 2'b00,
      FCRV_OP_VERIFY  = 2'b01,
      FCRV_OP_VERSION = 2'b10,
      FCRV_OP_WRITE   = 2'b11
   } fcrv_op_t;

   typedef struct packed {
      fcrv_op_t    op;
      logic        multi_track_flag;
      logic        double_density_flag;
      logic        skip_deleted_flag;
      logic        enable_count_flag;
      logic        head_select;
      logic        drive_select_hi;
      logic        drive_select_lo;
      logic [7:0]  cylinder;
      logic [7:0]  head;
      logic [7:0]  sector;
      logic [7:0]  size_code;
      logic [7:0]  final_sector_number;
      logic [7:0]  gap_length;
      logic [7:0]  data_length;
   } fcrv_req_t;

   typedef struct packed {
      logic [7:0]  result_status_zero;
      logic [7:0]  result_status_one;
      logic [7:0]  result_status_two;
      logic [7:0]  cylinder;
      logic [7:0]  head;
      logic [7:0]  sector;
      logic [7:0]  size_code;
   } fcrv_res_t;

endpackage
`default_nettype wire

// ---- rtl/fcrv_top.sv ----
// Command, execution and result sequencer for four floppy commands
//
// Notes on behaviour
// (RULE1) Read ID: two bytes, capture first ID
// (RULE2) Read ID returns three status, then C,H,R,N
// (RULE3) Verify: flags, select, seven parameter bytes
// (RULE4) Verify moves no sector data at all
// (RULE5) Verify/write return status then final C,H,R,N
// (RULE6) Version byte 0x10 answers 0x90, no execution
// (RULE7) Write: flags, select, seven parameters, data in
// (RULE8) Host keeps byte order, drains all results
`timescale 1ns/10ps
`default_nettype none
`include "fcrv_defs.svh"

module fcrv_top (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_b,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // Interrupt
   output logic                   irq,
   // Execution request to the drive side
   output logic                   exec_start,
   output fcrv_pkg::fcrv_req_t    exec_req,
   input  wire logic              exec_done,
   input  wire fcrv_pkg::fcrv_res_t exec_res,
   // Write data stream toward the drive
   output logic                   wr_valid,
   output logic [7:0]             wr_byte,
   input  wire logic              wr_ready
);
   import fcrv_pkg::*;

   // Sequencer state
   fcrv_state_t           state_r;
   fcrv_op_t              op_r;
   // Stored command, parameter and result bytes
   logic [7:0]            cmd_r;
   logic [7:0]            par_r [0:7];
   logic [7:0]            res_r [0:6];
   logic [3:0]            par_cnt_r;
   logic [3:0]            par_need_r;
   logic [2:0]            res_idx_r;
   logic [2:0]            res_last_r;
   logic                  launched_r;
   logic [`FCRV_IRQ_W-1:0] irq_stat_r;
   logic [`FCRV_IRQ_W-1:0] irq_mask_r;
   // Interrupt state and events
   logic [`FCRV_IRQ_W-1:0] irq_ev;
   logic [`FCRV_IRQ_W-1:0] irq_clr;
   logic [`FCRV_IRQ_W-1:0] irq_stat_nxt;

   // Bus decode
   logic                  access;
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  hit_data;
   logic                  hit_status;
   logic                  hit_istat;
   logic                  hit_imask;
   logic                  hit_ctrl;
   logic                  mapped;
   logic                  data_wr;
   logic                  data_rd;
   logic                  abort;
   logic [31:0]           rd_mux;

   // Command decode
   logic [7:0]            cmd_in;
   logic                  is_rdid;
   logic                  is_verify;
   logic                  is_write;
   logic                  is_version;
   logic                  res_enter;
   logic                  exec_finish;
   fcrv_req_t             req_nxt;
   logic                  launch;
   logic [31:0]           status_word;

   // APB decode; a transfer completes at the edge that sees pready high
   assign access     = psel & penable;
   assign wr_fire    = access & pready & pwrite;
   assign rd_fire    = access & pready & ~pwrite;
   assign hit_data   = (paddr == `FCRV_OFF_DATA);
   assign hit_status = (paddr == `FCRV_OFF_STATUS);
   assign hit_istat  = (paddr == `FCRV_OFF_IRQ_STAT);
   assign hit_imask  = (paddr == `FCRV_OFF_IRQ_MASK);
   assign hit_ctrl   = (paddr == `FCRV_OFF_CTRL);
   assign mapped     = hit_data | hit_status | hit_istat | hit_imask |
                       hit_ctrl;
   assign data_wr    = wr_fire & hit_data;
   assign data_rd    = rd_fire & hit_data;
   assign abort      = wr_fire & hit_ctrl & pwdata[`FCRV_CTRL_ABORT];

   // Command byte decode
   assign cmd_in     = pwdata[7:0];
   assign is_rdid    = (cmd_in & `FCRV_RDID_MASK) == `FCRV_RDID_CODE;  // RULE1
   assign is_verify  = (cmd_in & `FCRV_VERIFY_MASK) == `FCRV_VERIFY_CODE; // RULE3
   assign is_write   = (cmd_in & `FCRV_WRITE_MASK) == `FCRV_WRITE_CODE; // RULE7
   assign is_version = (cmd_in == `FCRV_VERSION_CODE);                 // RULE6

   // Result phase opens on a short command or on execution end
   assign exec_finish = (state_r == FCRV_EXEC) & launched_r & exec_done;
   assign launch      = (state_r == FCRV_EXEC) & ~launched_r & ~abort;
   assign res_enter   = ((state_r == FCRV_IDLE) & data_wr &
                         ~is_rdid & ~is_verify & ~is_write) |
                        exec_finish;

   // Status word: phase flags and stream backpressure
   always_comb begin
      status_word                        = 32'h0000_0000;
      status_word[`FCRV_ST_BUSY]    = (state_r != FCRV_IDLE);
      status_word[`FCRV_ST_EXEC]    = (state_r == FCRV_EXEC);
      status_word[`FCRV_ST_RESULT]  = (state_r == FCRV_RESULT);
      status_word[`FCRV_ST_WR_FULL] = wr_valid;
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_data && state_r == FCRV_RESULT) begin
         rd_mux = {24'h00_0000, res_r[res_idx_r]};
      end else if (hit_status) begin
         rd_mux = status_word;
      end else if (hit_istat) begin
         rd_mux[`FCRV_IRQ_W-1:0] = irq_stat_r;
      end else if (hit_imask) begin
         rd_mux[`FCRV_IRQ_W-1:0] = irq_mask_r;
      end
   end

   // One wait state: pready rises the cycle after the access phase opens
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access & ~pready;
         // Error flag stands with pready only, never longer
         pslverr <= access & ~pready & ~mapped;
         // Read data captured a cycle early; stands with pready
         if (access && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // Request built from the stored command and parameter bytes
   // Read ID carries only the density flag and selects; the rest stays zero
   always_comb begin
      req_nxt                     = '0;
      req_nxt.op                  = op_r;
      req_nxt.double_density_flag = cmd_r[`FCRV_B_DOUBLE_DENS]; // RULE1
      req_nxt.head_select         = par_r[0][`FCRV_B_HEAD];
      req_nxt.drive_select_hi     = par_r[0][1];
      req_nxt.drive_select_lo     = par_r[0][0];
      if (op_r != FCRV_OP_READID) begin
         req_nxt.multi_track_flag    = cmd_r[`FCRV_B_MULTI_TRACK]; // RULE7
         req_nxt.cylinder            = par_r[1];
         req_nxt.head                = par_r[2];
         req_nxt.sector              = par_r[3];
         req_nxt.size_code           = par_r[4];
         req_nxt.final_sector_number = par_r[5];
         req_nxt.gap_length          = par_r[6];
         req_nxt.data_length         = par_r[7];
      end
      if (op_r == FCRV_OP_VERIFY) begin
         req_nxt.skip_deleted_flag = cmd_r[`FCRV_B_SKIP_DEL];    // RULE3
         req_nxt.enable_count_flag = par_r[0][`FCRV_B_ENABLE_CNT]; // RULE3
      end
   end

   // Launch pulse and request; request holds until the next launch
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         exec_start <= 1'b0;
         exec_req   <= '0;
      end else begin
         exec_start <= launch;
         if (launch) begin
            exec_req <= req_nxt;
         end
      end
   end

   // Command, parameter, execution and result sequencing
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_r    <= FCRV_IDLE;
         op_r       <= FCRV_OP_READID;
         cmd_r      <= 8'h00;
         par_cnt_r  <= 4'h0;
         par_need_r <= 4'h0;
         res_idx_r  <= 3'h0;
         res_last_r <= 3'h0;
         launched_r <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            par_r[i] <= 8'h00;
         end
         for (int i = 0; i < 7; i++) begin
            res_r[i] <= 8'h00;
         end
      end else begin
         if (abort) begin
            state_r    <= FCRV_IDLE;
            launched_r <= 1'b0;
         end else begin
            case (state_r)
               FCRV_IDLE: begin
                  // Command byte picks the operation and byte count
                  if (data_wr) begin
                     cmd_r     <= cmd_in;
                     par_cnt_r <= 4'h0;
                     res_idx_r <= 3'h0;
                     if (is_rdid) begin
                        op_r       <= FCRV_OP_READID;
                        par_need_r <= `FCRV_NPAR_RDID;   // RULE1
                        state_r    <= FCRV_PARAM;
                     end else if (is_verify) begin
                        op_r       <= FCRV_OP_VERIFY;
                        par_need_r <= `FCRV_NPAR_LONG;   // RULE3
                        state_r    <= FCRV_PARAM;
                     end else if (is_write) begin
                        op_r       <= FCRV_OP_WRITE;
                        par_need_r <= `FCRV_NPAR_LONG;   // RULE7
                        state_r    <= FCRV_PARAM;
                     end else if (is_version) begin
                        op_r       <= FCRV_OP_VERSION;
                        res_r[0]   <= `FCRV_VERSION_ANS; // RULE6
                        res_last_r <= `FCRV_NRES_ONE;
                        state_r    <= FCRV_RESULT;
                     end else begin
                        // Unknown code: single invalid status byte
                        res_r[0]   <= `FCRV_INVALID_ANS;
                        res_last_r <= `FCRV_NRES_ONE;
                        state_r    <= FCRV_RESULT;
                     end
                  end
               end

               FCRV_PARAM: begin
                  // Bytes land in arrival order; host keeps that order
                  if (data_wr) begin                      // RULE8
                     par_r[par_cnt_r[2:0]] <= cmd_in;
                     par_cnt_r             <= par_cnt_r + 4'h1;
                     if (par_cnt_r + 4'h1 == par_need_r) begin
                        state_r    <= FCRV_EXEC;
                        launched_r <= 1'b0;
                     end
                  end
               end

               FCRV_EXEC: begin
                  // Launch one cycle late so the last byte is stored
                  if (!launched_r) begin
                     launched_r <= 1'b1;
                  end else if (exec_done) begin
                     launched_r <= 1'b0;
                     res_r[0]   <= exec_res.result_status_zero; // RULE2
                     res_r[1]   <= exec_res.result_status_one;  // RULE5
                     res_r[2]   <= exec_res.result_status_two;
                     res_r[3]   <= exec_res.cylinder;
                     res_r[4]   <= exec_res.head;
                     res_r[5]   <= exec_res.sector;
                     res_r[6]   <= exec_res.size_code;
                     res_last_r <= `FCRV_NRES_FULL;
                     res_idx_r  <= 3'h0;
                     state_r    <= FCRV_RESULT;
                  end
               end

               FCRV_RESULT: begin
                  // Next command only after the last byte is drained
                  if (data_rd) begin                      // RULE8
                     if (res_idx_r == res_last_r) begin
                        state_r <= FCRV_IDLE;
                     end else begin
                        res_idx_r <= res_idx_r + 3'h1;
                     end
                  end
               end

               default: begin
                  state_r <= FCRV_IDLE;
               end
            endcase
         end
      end
   end

   // Sector data for write only; verify and read ID never touch it
   // A byte written while the drive stalls is lost; host polls STATUS
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_valid <= 1'b0;
         wr_byte  <= 8'h00;
      end else begin
         if (data_wr && state_r == FCRV_EXEC && launched_r &&
             op_r == FCRV_OP_WRITE && (!wr_valid || wr_ready)) begin
            wr_valid <= 1'b1;                             // RULE7
            wr_byte  <= cmd_in;
         end else if (wr_ready || abort || state_r != FCRV_EXEC) begin
            wr_valid <= 1'b0;                             // RULE4
         end
      end
   end

   // Interrupt events
   assign irq_ev[`FCRV_IRQ_RESULT]  = res_enter;
   assign irq_ev[`FCRV_IRQ_INVALID] = (state_r == FCRV_IDLE) & data_wr &
                                      ~is_rdid & ~is_verify & ~is_write &
                                      ~is_version;
   assign irq_ev[`FCRV_IRQ_EXEC]    = exec_start;

   // Per-bit sticky status; a new event beats a same-cycle clear
   for (genvar b = 0; b < `FCRV_IRQ_W; b++) begin : g_irq
      assign irq_clr[b]      = wr_fire & hit_istat & pwdata[b];
      assign irq_stat_nxt[b] = irq_ev[b] | (irq_stat_r[b] & ~irq_clr[b]);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_r <= `FCRV_IRQ_RESET;
         irq_mask_r <= `FCRV_IRQ_RESET;
         irq        <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr_fire && hit_imask) begin
            irq_mask_r <= pwdata[`FCRV_IRQ_W-1:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

endmodule
`default_nettype wire

// ---- test/fcrv_checker.sv ----
// Port assertions for the floppy command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fcrv_defs.svh"
module fcrv_checker (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                rst_b,
   // APB
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pready,
   input wire logic [31:0]         prdata,
   input wire logic                pslverr,
   input wire logic                irq,
   // Drive side
   input wire logic                exec_start,
   input wire fcrv_pkg::fcrv_req_t exec_req,
   input wire logic                exec_done,
   input wire fcrv_pkg::fcrv_res_t exec_res,
   input wire logic                wr_valid,
   input wire logic [7:0]          wr_byte,
   input wire logic                wr_ready
);
   import fcrv_pkg::*;
   wire logic data_commit = psel && penable && pready && pwrite
                            && (paddr == `FCRV_OFF_DATA);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_apb_one_wait: assert property (psel && penable && !pready |=>
      pready ##1 !pready) else $error("apb answer not after one wait");
   a_slverr_quiet: assert property (pslverr |-> pready
      && prdata == 32'h0) else $error("error answer malformed");
   a_start_after_byte: assert property (exec_start |->
      $past(data_commit, 2)) else $error("launch not after a data byte");
   a_req_held: assert property (!exec_start |->
      $stable(exec_req)) else $error("request changed between launches");
   a_version_no_exec: assert property (exec_start |->
      exec_req.op != FCRV_OP_VERSION) else $error("version launched");
   a_verify_no_stream: assert property (wr_valid |->
      exec_req.op == FCRV_OP_WRITE) else $error("stream outside write");
   a_stream_hold: assert property (wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_byte)) else $error("stream byte not held");
   a_stream_cause: assert property ($rose(wr_valid) |->
      $past(data_commit)) else $error("stream byte without host write");
   a_readid_fields: assert property (exec_start &&
      exec_req.op == FCRV_OP_READID |-> exec_req.cylinder == 8'h00)
      else $error("read id request carries stray fields");

   c_readid: cover property (exec_start && exec_req.op == FCRV_OP_READID);
   c_verify: cover property (exec_start && exec_req.op == FCRV_OP_VERIFY);
   c_write: cover property (exec_start && exec_req.op == FCRV_OP_WRITE);
   c_stream: cover property (wr_valid && wr_ready);
endmodule

bind fcrv_top fcrv_checker u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
   .exec_start(exec_start), .exec_req(exec_req), .exec_done(exec_done),
   .exec_res(exec_res), .wr_valid(wr_valid), .wr_byte(wr_byte),
   .wr_ready(wr_ready));
`default_nettype wire

// ---- test/fcrv_drive_model.sv ----
// Behavioural disk drive answering execution requests
`timescale 1ns/10ps
`default_nettype none
module fcrv_drive_model (
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   // Execution handshake
   input  wire logic                exec_start,
   input  wire fcrv_pkg::fcrv_req_t exec_req,
   input  wire logic [7:0]          lat,
   output logic                     exec_done,
   output fcrv_pkg::fcrv_res_t      exec_res,
   // Write stream and its tally
   input  wire logic                wr_valid,
   input  wire logic [7:0]          wr_byte,
   output logic                     wr_ready,
   output logic [7:0]               n_taken,
   output logic [7:0]               last_byte
);
   import fcrv_pkg::*;
   logic [7:0] cnt_r;
   fcrv_res_t  res_w;
   logic       rdid_w;

   assign rdid_w = (exec_req.op == FCRV_OP_READID);
   always_comb begin
      res_w.result_status_zero = {5'h00, exec_req.head_select,
         exec_req.drive_select_hi, exec_req.drive_select_lo};
      res_w.result_status_one = 8'h20;
      res_w.result_status_two = 8'h40;
      // First ID on the cylinder is a fixed one here
      res_w.cylinder = rdid_w ? 8'h21 : exec_req.cylinder;
      res_w.head = rdid_w ? 8'h01 : exec_req.head;
      res_w.sector = rdid_w ? 8'h07 : exec_req.final_sector_number;
      res_w.size_code = rdid_w ? 8'h02 : exec_req.size_code;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= 8'h00;
         exec_done <= 1'b0;
         exec_res <= '0;
         wr_ready <= 1'b0;
         n_taken <= 8'h00;
         last_byte <= 8'h00;
      end else begin
         exec_done <= (cnt_r == 8'h01);
         if (exec_start) begin
            cnt_r <= lat;
         end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
         end
         // Garbage outside the done cycle, so stale sampling shows
         exec_res <= (cnt_r == 8'h01) ? res_w : ~res_w;
         // Stalls every other cycle
         wr_ready <= ~wr_ready;
         if (wr_valid && wr_ready) begin
            n_taken <= n_taken + 8'h01;
            last_byte <= wr_byte;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/fcrv_top_tb_top.sv ----
// Directed testbench for the floppy command sequencer
`timescale 1ns/10ps
`default_nettype none
`include "fcrv_defs.svh"
module fcrv_top_tb_top;
   import fcrv_pkg::*;
   logic             mclk = 1'b0;
   logic             rst_b = 1'b0;
   logic             psel = 1'b0;
   logic             penable = 1'b0;
   logic             pwrite = 1'b0;
   logic [7:0]       paddr = 8'h00;
   logic [31:0]      pwdata = 32'h0;
   logic [7:0]       lat = 8'h05;
   wire logic        pready, pslverr, irq, exec_start, exec_done;
   wire logic        wr_valid, wr_ready;
   wire logic [31:0] prdata;
   wire logic [7:0]  wr_byte, n_taken, last_byte;
   wire fcrv_req_t   exec_req;
   wire fcrv_res_t   exec_res;
   int               n_mismatch = 0;
   int               checks_done = 0;
   logic [31:0]      q;
   logic             err;

   always #25 mclk = ~mclk;

   fcrv_top DUT (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .irq(irq), .exec_start(exec_start),
      .exec_req(exec_req), .exec_done(exec_done), .exec_res(exec_res),
      .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ready(wr_ready));
   fcrv_drive_model u_drive (.mclk(mclk), .rst_b(rst_b),
      .exec_start(exec_start), .exec_req(exec_req), .lat(lat),
      .exec_done(exec_done), .exec_res(exec_res), .wr_valid(wr_valid),
      .wr_byte(wr_byte), .wr_ready(wr_ready), .n_taken(n_taken),
      .last_byte(last_byte));

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic bad;
      bad = !(a inside {`FCRV_OFF_DATA, `FCRV_OFF_STATUS, `FCRV_OFF_IRQ_STAT,
                        `FCRV_OFF_IRQ_MASK, `FCRV_OFF_CTRL});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
      check("apb error", {31'h0, err}, {31'h0, bad});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      apb(1'b0, a, 32'h0);
      check(nm, q, e);
   endtask

   task automatic put(input logic [71:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         apb(1'b1, `FCRV_OFF_DATA, {24'h0, v[8*(n-1-i) +: 8]});
      end
   endtask

   task automatic get(input logic [55:0] e);
      for (int i = 0; i < 7; i++) begin
         rd(`FCRV_OFF_DATA, {24'h0, e[8*(6-i) +: 8]}, "result byte");
      end
   endtask

   task automatic poll(input int b, input logic want);
      int n;
      n = 0;
      do begin
         apb(1'b0, `FCRV_OFF_STATUS, 32'h0);
         n++;
      end while (q[b] !== want && n < 100);
      check("status poll", 32'(n < 100), 32'h1);
   endtask

   task automatic irq_is(input logic e);
      @(posedge mclk);
      check("irq", {31'h0, irq}, {31'h0, e});
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      n_mismatch++;
      results();
   end

   initial begin
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rd(`FCRV_OFF_STATUS, 32'h0, "status idle");
      rd(`FCRV_OFF_IRQ_MASK, 32'h0, "mask reset");
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      wr_mask: apb(1'b1, `FCRV_OFF_IRQ_MASK, 32'h7);
      put(72'h10, 1);
      poll(`FCRV_ST_RESULT, 1'b1);
      rd(`FCRV_OFF_DATA, 32'h90, "version answer");
      rd(`FCRV_OFF_STATUS, 32'h0, "after version");
      irq_is(1'b1);
      apb(1'b1, `FCRV_OFF_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      apb(1'b1, `FCRV_OFF_IRQ_MASK, 32'h7);
      irq_is(1'b1);
      apb(1'b1, `FCRV_OFF_IRQ_STAT, 32'h7);
      irq_is(1'b0);
      put(72'h4a06, 2);
      poll(`FCRV_ST_RESULT, 1'b1);
      check("rdid req", {exec_req.op, exec_req.double_density_flag,
         exec_req.head_select, exec_req.drive_select_hi,
         exec_req.drive_select_lo}, {FCRV_OP_READID, 4'he});
      get(56'h06_20_40_21_01_07_02);
      rd(`FCRV_OFF_IRQ_STAT, 32'h5, "irq status");
      apb(1'b1, `FCRV_OFF_IRQ_STAT, 32'h7);
      put(72'hf6_85_10_01_03_02_09_1b_ff, 9);
      poll(`FCRV_ST_RESULT, 1'b1);
      check("verify flags", {exec_req.op, exec_req.multi_track_flag,
         exec_req.double_density_flag, exec_req.skip_deleted_flag,
         exec_req.enable_count_flag, exec_req.head_select,
         exec_req.drive_select_hi, exec_req.drive_select_lo},
         {FCRV_OP_VERIFY, 7'h7d});
      check("verify params", {exec_req.cylinder,
         exec_req.final_sector_number, exec_req.gap_length,
         exec_req.data_length}, 32'h10091bff);
      get(56'h05_20_40_10_01_09_02);
      check("verify stream", {24'h0, n_taken}, 32'h0);
      lat <= 8'h50;
      put(72'hc5_00_03_00_01_02_04_1b_80, 9);
      for (int i = 1; i < 4; i++) begin
         poll(`FCRV_ST_WR_FULL, 1'b0);
         apb(1'b1, `FCRV_OFF_DATA, {24'h0, 4'(i), 4'(i)});
      end
      poll(`FCRV_ST_WR_FULL, 1'b0);
      check("bytes taken", {24'h0, n_taken}, 32'h3);
      check("last byte", {24'h0, last_byte}, 32'h33);
      poll(`FCRV_ST_RESULT, 1'b1);
      check("write flags", {exec_req.op, exec_req.multi_track_flag,
         exec_req.double_density_flag}, {FCRV_OP_WRITE, 2'h3});
      get(56'h00_20_40_03_00_04_02);
      put(72'h0500, 2);
      apb(1'b1, `FCRV_OFF_CTRL, 32'h1);
      rd(`FCRV_OFF_STATUS, 32'h0, "after abort");
      apb(1'b1, `FCRV_OFF_IRQ_STAT, 32'h7);
      put(72'h00, 1);
      poll(`FCRV_ST_RESULT, 1'b1);
      rd(`FCRV_OFF_DATA, 32'h80, "invalid answer");
      rd(`FCRV_OFF_IRQ_STAT, 32'h3, "invalid irq");
      results();
   end
endmodule
`default_nettype wire
